/* File: bench/rtc_timebase_control_access_props.sv */
// Port-level checks for the time-base and access block.
// Assumes it is bound onto the block's top module.
`timescale 1ns/1ps
module rtc_timebase_control_access_props
  import rtc_tb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic nvram_bank_select_in,
  input wire logic osc_enable_out,
  input wire logic update_in_progress_out,
  input wire logic square_wave_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Bank select passes a two-flop sync, so it must be steady for a few edges
  rd_bank_err_a: assert property (
    $rose(s_axi_rvalid_out) && $past(nvram_bank_select_in, 2) && $past(nvram_bank_select_in, 3)
    && $past(nvram_bank_select_in, 4) |-> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 0)
    else $error("read reached a register with bank select high");
  wr_bank_err_a: assert property (
    $rose(s_axi_bvalid_out) && $past(nvram_bank_select_in, 2) && $past(nvram_bank_select_in, 3)
    && $past(nvram_bank_select_in, 4) |-> s_axi_bresp_out == RESP_SLVERR)
    else $error("write reached a register with bank select high");
  osc_off_busy_a: assert property (!osc_enable_out [*2] |-> !update_in_progress_out)
    else $error("update flag with oscillator stopped");
  sqw_quiet_a: assert property (!osc_enable_out [*3] |-> !square_wave_out)
    else $error("square wave with divider stopped");
  uip_window_a: assert property (
    $rose(update_in_progress_out) |=> update_in_progress_out [*8])
    else $error("update flag shorter than guard");
  wr_busy_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted during response");
  rd_busy_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted during response");
  rd_taken_a: assert property ($rose(s_axi_rvalid_out) |-> $past(s_axi_arvalid_in && s_axi_arready_out))
    else $error("read answer without a taken request");
endmodule : rtc_timebase_control_access_props

/* File: bench/rtc_timebase_control_access_test.sv */
// Self-checking bench for the time-base and access block.
// Assumes the crystal model and the checker from the bench folder.
`timescale 1ns/1ps
module rtc_timebase_control_access_test;
  import rtc_tb_pkg::*;
  // Just over two clocks per level: every edge still seen, run stays short
  localparam int XH_NS = 210;
  logic core_clk_in, arst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, nvram_bank_select_in, xtal_level_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, osc_enable_out, update_in_progress_out, square_wave_out, irq_out;
  int err_count, n_compared, c, t, u, e;
  // Rows: field pattern, oscillator enable, event bit writable
  logic [4:0] rows [8] = '{5'h00, 5'h04, 5'h0a, 5'h0f, 5'h10, 5'h14, 5'h1a, 5'h1e};

  rtc_timebase_control_access i_rtc_timebase_control_access (.*);
  xtal_source_model #(.HALF_NS(XH_NS)) i_xtal_source_model (
    .run_in(osc_enable_out),
    .level_out(xtal_level_in)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Readies are sampled at the falling edge, so the rising edge acts on settled values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int k;
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_araddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= w;
    s_axi_wvalid_in <= w;
    s_axi_arvalid_in <= !w;
    s_axi_bready_in <= w;
    s_axi_rready_in <= !w;
    tb = 1'b0;
    k = 0;
    while (!tb && k < 64) begin
      @(negedge core_clk_in);
      ta = w ? s_axi_awready_out : s_axi_arready_out;
      tw = s_axi_wready_out;
      tb = w ? s_axi_bvalid_out : s_axi_rvalid_out;
      rs = w ? s_axi_bresp_out : s_axi_rresp_out;
      rd = s_axi_rdata_out;
      @(posedge core_clk_in);
      if (ta) begin
        s_axi_awvalid_in <= 1'b0;
        s_axi_arvalid_in <= 1'b0;
      end
      if (tw) s_axi_wvalid_in <= 1'b0;
      k++;
    end
    s_axi_bready_in <= 1'b0;
    s_axi_rready_in <= 1'b0;
    if (!tb) err_count++;
  endtask : xfer

  task automatic tog(output int n);
    logic p;
    n = 0;
    // Skip the edge that may still carry the previous setting
    @(posedge core_clk_in);
    p = square_wave_out;
    repeat (100) begin
      @(posedge core_clk_in);
      if (square_wave_out !== p) n++;
      p = square_wave_out;
    end
  endtask : tog

  initial begin
    {arst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, nvram_bank_select_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hf;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk({osc_enable_out, update_in_progress_out, square_wave_out, irq_out}, '0);
    xfer(0, OFS_CTRL_A, '0);
    chk(rd, '0);
    xfer(0, OFS_IRQ_MASK, '0);
    chk(rd, 32'(IRQ_MASK_RESET));
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      xfer(1, OFS_CTRL_A, {rows[i][4:2], 4'h0});
      xfer(1, OFS_EVENT, 32'h0000_0004);
      chk(osc_enable_out, rows[i][1]);
      xfer(0, OFS_EVENT, '0);
      chk(rd[E_32K_BIT], rows[i][0]);
      xfer(0, OFS_CTRL_A, '0);
      chk(rd[6:4], rows[i][4:2]);
    end
    $display("pattern table done");
    xfer(1, OFS_CTRL_B, 32'h0000_0008);
    xfer(1, OFS_CTRL_A, 32'h0000_0030);
    xfer(1, OFS_EVENT, 32'h0000_0004);
    tog(c);
    chk(32'(c > 10), 1);
    // Fast rate, so a divider that ran would show on the pin
    xfer(1, OFS_CTRL_A, 32'h0000_0063);
    tog(c);
    chk(c, 0);
    $display("square wave test done");
    nvram_bank_select_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    xfer(1, OFS_CTRL_A, 32'h0000_0020);
    chk(rs, RESP_SLVERR);
    xfer(0, OFS_CTRL_A, '0);
    chk(rs, RESP_SLVERR);
    chk(rd, '0);
    nvram_bank_select_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    xfer(0, OFS_CTRL_A, '0);
    chk(rd[6:4], 3'h6);
    xfer(0, 8'h18, '0);
    chk(rs, RESP_SLVERR);
    $display("access test done");
    xfer(1, OFS_CTRL_B, 32'h0000_0050);
    xfer(1, OFS_IRQ_MASK, 32'h0000_0001);
    // Half-second events, so each update window falls between two events
    xfer(1, OFS_CTRL_A, 32'h0000_002f);
    t = 0;
    while (!update_in_progress_out && t < 80000) begin
      @(negedge core_clk_in);
      t++;
    end
    u = t;
    while (update_in_progress_out && t < 80000) begin
      @(negedge core_clk_in);
      t++;
    end
    e = (FIRST_UPDATE_TICKS - GUARD_TICKS - UPDATE_TICKS) * 2 * XH_NS / 100;
    chk(32'(u > e - 30 && u < e + 30), 1);
    e = FIRST_UPDATE_TICKS * 2 * XH_NS / 100;
    chk(32'(t > e - 30 && t < e + 30), 1);
    xfer(0, OFS_EVENT, '0);
    chk(rd[E_UPD_DONE_BIT], 1);
    chk(rd[E_PF_BIT], 1);
    chk(irq_out, 1);
    xfer(0, OFS_SECONDS, '0);
    chk(rd, 1);
    xfer(1, OFS_IRQ_MASK, '0);
    chk(irq_out, 0);
    xfer(1, OFS_IRQ_MASK, 32'h0000_0001);
    chk(irq_out, 1);
    xfer(1, OFS_IRQ_STAT, 32'h0000_0001);
    chk(irq_out, 0);
    $display("update test done");
    arst_n_in <= 1'b0;
    @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk({osc_enable_out, update_in_progress_out, square_wave_out, irq_out}, '0);
    xfer(0, OFS_CTRL_A, '0);
    chk(rd, '0);
    $display("mid-run reset test done");
    end_sim();
  end

  // First update alone takes about 6.9 ms of crystal ticks
  initial begin
    #8_500_000;
    err_count++;
    end_sim();
  end
endmodule : rtc_timebase_control_access_test

bind rtc_timebase_control_access rtc_timebase_control_access_props
  i_rtc_timebase_control_access_props (.*);

/* File: bench/xtal_source_model.sv */
// Crystal stand-in driving the block's crystal level pin.
// Assumes its run input comes from the block's oscillator enable.
`timescale 1ns/1ps
module xtal_source_model #(
  parameter int HALF_NS = 410
) (
  input wire logic run_in,
  output logic level_out
);
  // A stopped oscillator freezes its level; odd period keeps phase unrelated
  initial begin
    level_out = 1'b0;
    forever begin
      #(HALF_NS);
      if (run_in) level_out = ~level_out;
    end
  end
endmodule : xtal_source_model

/* File: rtl/rtc_tb_pkg.sv */
// Constants for the real-time clock time-base and access block.
// Assumes a 10 MHz core clock and a 32.768 kHz crystal level on a pin.
package rtc_tb_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int XTAL_HZ = 32768;
  localparam int AXI_ADDR_W = 8;
  // Byte addresses of the register words
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_SECONDS = 8'h14;
  // Control A fields
  localparam int A_BUSY_BIT = 7;
  localparam int A_TB_LSB = 4;
  localparam int A_RATE_LSB = 0;
  // Control B fields
  localparam int B_HOLD_BIT = 7;
  localparam int B_PIE_BIT = 6;
  localparam int B_UPD_IRQ_BIT = 4;
  localparam int B_SQWE_BIT = 3;
  // Event status fields
  localparam int E_INTF_BIT = 7;
  localparam int E_PF_BIT = 6;
  localparam int E_UPD_DONE_BIT = 4;
  localparam int E_32K_BIT = 2;
  // Interrupt status / mask bits
  localparam int IRQ_UPD_BIT = 0;
  localparam int IRQ_PER_BIT = 1;
  localparam int IRQ_W = 2;
  // Time-base control patterns
  localparam logic [2:0] TB_RUN = 3'h2;
  localparam logic [2:0] TB_RUN_WR = 3'h3;
  localparam logic [1:0] TB_OSC_ONLY_HI = 2'h3;
  // Reset values and response codes
  localparam logic [2:0] TB_RESET = 3'h0;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Divider and update-cycle timing, in crystal ticks
  localparam int DIV_W = 15;
  localparam logic [14:0] DIV_LAST = 15'h7fff;
  localparam int FIRST_UPDATE_MS = 500;
  localparam int FIRST_UPDATE_TICKS = FIRST_UPDATE_MS * XTAL_HZ / 1000;
  localparam int GUARD_US = 244;
  localparam int GUARD_TICKS = (GUARD_US * XTAL_HZ + 999999) / 1000000;
  localparam int UPDATE_US = 976;
  localparam int UPDATE_TICKS = (UPDATE_US * XTAL_HZ + 999999) / 1000000;
  localparam int NEXT_UPDATE_MIN_MS = 999;
  localparam logic [14:0] DIV_FIRST_LOAD = 15'(XTAL_HZ - FIRST_UPDATE_TICKS);
  localparam logic [14:0] UPD_START = 15'(XTAL_HZ - UPDATE_TICKS);
  localparam logic [14:0] BUSY_START = 15'(XTAL_HZ - UPDATE_TICKS - GUARD_TICKS);
endpackage : rtc_tb_pkg

/* File: rtl/rtc_timebase_control_access.sv */
// Real-time clock time base, update-cycle sequencing and register access.
// Assumes an AXI4-Lite master on core_clk_in and a free-running crystal level pin.
//
// Contract
// - Clock bytes read during an update cycle may be inconsistent.
// - After update-ended, the next update starts no sooner than 999 ms later.
// - While update-in-progress reads zero, no update begins within the guard time.
// - Pattern 011 runs like 010 and makes the event status register writable.
// - Under 011 the raw crystal frequency can be enabled onto the square-wave pin.
// - Pattern 11X runs the oscillator but holds the divider disabled.
// - Any other pattern keeps the oscillator stopped.
// - The first update cycle follows 500 ms after the enabling pattern.
// - Update-in-progress rises before each update, falls after it and is held low by hold.
// - Update-ended is flagged each cycle; it interrupts only with enable set and hold clear.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module rtc_timebase_control_access
  import rtc_tb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic nvram_bank_select_in,
  input wire logic xtal_level_in,
  output logic osc_enable_out,
  output logic update_in_progress_out,
  output logic square_wave_out,
  output logic irq_out
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] tb_field;
    logic [3:0] rate;
    logic hold;
    logic pie;
    logic upd_irq_en;
    logic sqwe;
    logic upd_done_flag;
    logic per_flag;
    logic khz32_en;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DIV_W-1:0] div;
    logic xtal_prev;
    logic tap_prev;
    logic [31:0] seconds;
    logic sq;
  } rtc_state_t;

  rtc_state_t s_reg;
  rtc_state_t s_next;
  logic [1:0] pins_sync;
  logic bank_sel;
  logic xtal_sync;

  sync_two_ff #(
    .WIDTH(2)
  ) i_sync_two_ff (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .async_in({nvram_bank_select_in, xtal_level_in}),
    .sync_out(pins_sync)
  );

  assign bank_sel = pins_sync[1];
  assign xtal_sync = pins_sync[0];

  // Decoded time-base state
  logic osc_run;
  logic div_run;
  logic xtal_tick;
  logic tap_now;
  logic upd_busy;
  logic upd_end;
  logic per_evt;
  logic irq_level;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] ctrl_a_rd;
  logic [7:0] ctrl_b_rd;
  logic [7:0] event_rd;
  logic [2:0] new_tb;
  logic new_div_run;

  function automatic logic tb_div_on(input logic [2:0] tb);
    tb_div_on = (tb == TB_RUN) || (tb == TB_RUN_WR);
  endfunction : tb_div_on

  // Divider tap for the rate select; codes 1 and 2 repeat codes 8 and 9
  function automatic logic tap_sel(input logic [3:0] rate, input logic [DIV_W-1:0] div);
    logic bit_out;
    bit_out = 1'b0;
    case (rate)
      4'h1: bit_out = div[6];
      4'h2: bit_out = div[7];
      4'h0: bit_out = 1'b0;
      default: bit_out = div[rate - 4'h2];
    endcase
    tap_sel = bit_out;
  endfunction : tap_sel

  always_comb begin
    osc_run = tb_div_on(s_reg.tb_field) ||
              (s_reg.tb_field[2:1] == TB_OSC_ONLY_HI);
    div_run = tb_div_on(s_reg.tb_field);
    xtal_tick = osc_run && xtal_sync && !s_reg.xtal_prev;
    tap_now = tap_sel(s_reg.rate, s_reg.div);
    // Flag rises a guard time ahead of the update window
    upd_busy = div_run && !s_reg.hold && (s_reg.div >= BUSY_START);
    upd_end = div_run && xtal_tick && (s_reg.div == DIV_LAST);
    per_evt = div_run && (s_reg.rate != RATE_RESET) && tap_now && !s_reg.tap_prev;
    irq_level = |(s_reg.irq_stat & s_reg.irq_mask);
    ctrl_a_rd = {upd_busy, s_reg.tb_field, s_reg.rate};
    ctrl_b_rd = {s_reg.hold, s_reg.pie, 1'b0, s_reg.upd_irq_en, s_reg.sqwe, 3'h0};
    event_rd = {irq_level, s_reg.per_flag, 1'b0, s_reg.upd_done_flag, 1'b0,
                s_reg.khz32_en, 2'h0};
    aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    w_hs = s_axi_wvalid_in && s_axi_wready_out;
    wr_addr = s_reg.aw_got ? s_reg.aw_addr : s_axi_awaddr_in;
    wr_data = s_reg.w_got ? s_reg.w_data : s_axi_wdata_in;
    wr_strb = s_reg.w_got ? s_reg.w_strb : s_axi_wstrb_in;
    do_write = (s_reg.aw_got || aw_hs) && (s_reg.w_got || w_hs) && !s_reg.bvalid;
    new_tb = wr_data[A_TB_LSB +: 3];
    new_div_run = tb_div_on(new_tb);

    s_next = s_reg;
    s_next.xtal_prev = xtal_sync;
    s_next.tap_prev = tap_now;

    // Write channel, address and data accepted in either order
    if (aw_hs) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr_in;
    end
    if (w_hs) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata_in;
      s_next.w_strb = s_axi_wstrb_in;
    end
    if (s_reg.bvalid && s_axi_bready_in) begin
      s_next.bvalid = 1'b0;
    end

    // Divider: held at zero while disabled, counts crystal edges otherwise
    if (!div_run) begin
      s_next.div = '0;
    end else if (xtal_tick) begin
      s_next.div = s_reg.div + 15'h0001;
    end
    if (upd_end && !s_reg.hold) begin
      s_next.seconds = s_reg.seconds + 32'h0000_0001;
    end

    // Interrupt status: W1C first, hardware set after so the event wins
    if (do_write && wr_strb[0] && !bank_sel && (wr_addr == OFS_IRQ_STAT)) begin
      s_next.irq_stat = s_reg.irq_stat & ~wr_data[IRQ_W-1:0];
    end

    if (do_write) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (bank_sel) begin
        s_next.bresp = RESP_SLVERR;
      end else begin
        case (wr_addr)
          OFS_CTRL_A: begin
            if (wr_strb[0]) begin
              s_next.tb_field = new_tb;
              s_next.rate = wr_data[A_RATE_LSB +: 4];
              // Entering a running pattern: first wrap comes half a second later
              if (new_div_run && !div_run) begin
                s_next.div = DIV_FIRST_LOAD;
              end
            end
          end
          OFS_CTRL_B: begin
            if (wr_strb[0]) begin
              s_next.hold = wr_data[B_HOLD_BIT];
              s_next.pie = wr_data[B_PIE_BIT];
              s_next.upd_irq_en = wr_data[B_UPD_IRQ_BIT] && !wr_data[B_HOLD_BIT];
              s_next.sqwe = wr_data[B_SQWE_BIT];
            end
          end
          OFS_EVENT: begin
            // Writable only under the test pattern, otherwise silently kept
            if (wr_strb[0] && (s_reg.tb_field == TB_RUN_WR)) begin
              s_next.per_flag = wr_data[E_PF_BIT];
              s_next.upd_done_flag = wr_data[E_UPD_DONE_BIT];
              s_next.khz32_en = wr_data[E_32K_BIT];
            end
          end
          OFS_IRQ_STAT: begin
          end
          OFS_IRQ_MASK: begin
            if (wr_strb[0]) begin
              s_next.irq_mask = wr_data[IRQ_W-1:0];
            end
          end
          default: s_next.bresp = RESP_SLVERR;
        endcase
      end
    end

    // Leaving the test pattern drops the raw-crystal selection
    if (s_next.tb_field != TB_RUN_WR) begin
      s_next.khz32_en = 1'b0;
    end

    // Event flags; set after any software write so events are never lost
    if (upd_end) begin
      s_next.upd_done_flag = 1'b1;
      if (s_reg.upd_irq_en && !s_reg.hold) begin
        s_next.irq_stat[IRQ_UPD_BIT] = 1'b1;
      end
    end
    if (per_evt) begin
      s_next.per_flag = 1'b1;
      if (s_reg.pie) begin
        s_next.irq_stat[IRQ_PER_BIT] = 1'b1;
      end
    end

    // Square wave: raw crystal under test pattern with the 32 kHz bit set, else the divider tap
    if (!s_reg.sqwe) begin
      s_next.sq = 1'b0;
    end else if ((s_reg.tb_field == TB_RUN_WR) && s_reg.khz32_en) begin
      s_next.sq = xtal_sync;
    end else begin
      s_next.sq = div_run && (s_reg.rate != RATE_RESET) && tap_now;
    end

    // Read channel; values are live, so time bytes may move mid-update
    if (s_reg.rvalid && s_axi_rready_in) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      if (bank_sel) begin
        s_next.rresp = RESP_SLVERR;
      end else begin
        case (s_axi_araddr_in)
          OFS_CTRL_A: s_next.rdata = {24'h00_0000, ctrl_a_rd};
          OFS_CTRL_B: s_next.rdata = {24'h00_0000, ctrl_b_rd};
          OFS_EVENT: s_next.rdata = {24'h00_0000, event_rd};
          OFS_IRQ_STAT: s_next.rdata = 32'(s_reg.irq_stat);
          OFS_IRQ_MASK: s_next.rdata = 32'(s_reg.irq_mask);
          OFS_SECONDS: s_next.rdata = s_reg.seconds;
          default: s_next.rresp = RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready_out = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready_out = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid_out = s_reg.bvalid;
  assign s_axi_bresp_out = s_reg.bresp;
  assign s_axi_arready_out = !s_reg.rvalid;
  assign s_axi_rvalid_out = s_reg.rvalid;
  assign s_axi_rdata_out = s_reg.rdata;
  assign s_axi_rresp_out = s_reg.rresp;
  assign osc_enable_out = osc_run;
  assign update_in_progress_out = upd_busy;
  assign square_wave_out = s_reg.sq;
  assign irq_out = irq_level;
endmodule : rtc_timebase_control_access

/* File: rtl/sync_two_ff.sv */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes levels only; pulses shorter than one clock may be lost.
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb begin
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;
endmodule : sync_two_ff
